// ### hw/ctu_top.v
// Design decisions made here: the APB register port and the address map.
`include "ctu_consts.vh"
module ctu_top
#(
  parameter ADDR_W = 8,
  parameter CNT_W  = 8
)
(
  // Clock and reset
  input  wire              pclk,
  input  wire              presetn,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  // Coprocessor handshake
  output wire [31:0]       cp_instr,
  output wire              cp_offer,
  input  wire              coproc_absent_line,
  input  wire              coproc_busy_line,
  input  wire              cp_last,
  // Coprocessor data
  input  wire [31:0]       cp_store_data,
  output wire [31:0]       cp_load_data,
  output wire              cp_load_valid,
  input  wire [31:0]       cp_reg_in,
  output wire [31:0]       cp_reg_out,
  output wire              cp_reg_valid,
  // Memory
  output wire              mem_req,
  output wire              mem_write,
  output wire              mem_seq,
  output wire [31:0]       mem_addr,
  output wire [31:0]       mem_wdata,
  input  wire [31:0]       mem_rdata,
  input  wire              mem_abort,
  // Traps
  output reg               trap_undef,
  output reg               trap_abort
);
  // ========================================================
  // States
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_OFFER = 3'h1;
  localparam [2:0] ST_MEMW  = 3'h2;
  localparam [2:0] ST_TAILN = 3'h3;
  localparam [2:0] ST_REGC  = 3'h4;
  localparam [2:0] ST_REGI  = 3'h5;

  // ========================================================
  // Condition check
  function cond_pass;
    input [3:0] cond;
    input [3:0] f;
    begin
      case (cond)
        `CTU_C_EQ: cond_pass = f[`CTU_B_FZ];
        `CTU_C_NE: cond_pass = ~f[`CTU_B_FZ];
        `CTU_C_CS: cond_pass = f[`CTU_B_FC];
        `CTU_C_CC: cond_pass = ~f[`CTU_B_FC];
        `CTU_C_MI: cond_pass = f[`CTU_B_FN];
        `CTU_C_PL: cond_pass = ~f[`CTU_B_FN];
        `CTU_C_VS: cond_pass = f[`CTU_B_FV];
        `CTU_C_VC: cond_pass = ~f[`CTU_B_FV];
        `CTU_C_HI: cond_pass = f[`CTU_B_FC] & ~f[`CTU_B_FZ];
        `CTU_C_LS: cond_pass = ~f[`CTU_B_FC] | f[`CTU_B_FZ];
        `CTU_C_GE: cond_pass = f[`CTU_B_FN] == f[`CTU_B_FV];
        `CTU_C_LT: cond_pass = f[`CTU_B_FN] != f[`CTU_B_FV];
        `CTU_C_GT: cond_pass = ~f[`CTU_B_FZ] &
                               (f[`CTU_B_FN] == f[`CTU_B_FV]);
        `CTU_C_LE: cond_pass = f[`CTU_B_FZ] |
                               (f[`CTU_B_FN] != f[`CTU_B_FV]);
        `CTU_C_AL: cond_pass = 1'b1;
        default:   cond_pass = 1'b0;
      endcase
    end
  endfunction

  // ========================================================
  // Registers
  reg [2:0]       state_ff;
  reg [2:0]       nxt_state;
  reg [31:0]      instr_ff;
  reg [31:0]      base_ff;
  reg [31:0]      pc_ff;
  reg [31:0]      core_ff;
  reg [3:0]       flags_ff;
  reg [31:0]      newbase_ff;
  reg [31:0]      result_ff;
  reg [31:0]      addr_ff;
  reg [31:0]      regout_ff;
  reg             first_ff;
  reg             done_ff;
  reg             skip_ff;
  reg             undef_ff;
  reg             abort_ff;
  reg             wb_ff;
  reg [CNT_W-1:0] cs_ff;
  reg [CNT_W-1:0] cn_ff;
  reg [CNT_W-1:0] ci_ff;
  reg [CNT_W-1:0] cc_ff;
  reg [31:0]      nxt_prdata;
  reg             nxt_err;
  reg             err_ff;

  wire [31:0] first_addr;
  wire [31:0] mod_base;
  wire        busy;
  wire        wr_acc;
  wire        rd_setup;
  wire        start;
  wire        is_reg;
  wire        dir_l;
  wire        rd_is_pc;
  wire        accept;
  wire        refuse;
  wire        wait_busy;
  wire        set_done;
  wire        set_skip;
  wire        set_undef;
  wire        set_abort;
  wire        set_wb;
  wire [31:0] w1c;
  wire [31:0] cost_word;

  assign busy     = state_ff != ST_IDLE;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign start    = wr_acc & (paddr == `CTU_OFS_CTRL) &
                    pwdata[`CTU_B_START] & ~busy;
  assign is_reg   = instr_ff[`CTU_B_REGX];
  assign dir_l    = instr_ff[`CTU_B_L];
  assign rd_is_pc = instr_ff[`CTU_F_RD] == `CTU_PC_IDX;
  assign w1c      = wr_acc & (paddr == `CTU_OFS_STATUS) ?
                    pwdata : `CTU_RST_WORD;

  // ========================================================
  // Handshake decode
  assign refuse    = coproc_absent_line & coproc_busy_line;
  assign wait_busy = ~coproc_absent_line & coproc_busy_line;
  assign accept    = ~coproc_absent_line & ~coproc_busy_line;

  // ========================================================
  // Address generation
  ctu_addr_gen u_addr
  (
    .base       (base_ff),
    .pc         (pc_ff),
    .base_is_pc (instr_ff[`CTU_F_RN] == `CTU_PC_IDX),
    .ofs_words  (instr_ff[`CTU_F_OFS]),
    .up         (instr_ff[`CTU_B_U]),
    .pre        (instr_ff[`CTU_B_P]),
    .first_addr (first_addr),
    .new_base   (mod_base)
  );

  // ========================================================
  // Next state
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (start && cond_pass(instr_ff[`CTU_F_COND], flags_ff))
          nxt_state = ST_OFFER;
      ST_OFFER:
        if (refuse)
          nxt_state = ST_IDLE;
        else if (accept)
          nxt_state = is_reg ? ST_REGC : ST_MEMW;
      ST_MEMW:
        if (mem_abort)
          nxt_state = ST_IDLE;
        else if (cp_last)
          nxt_state = ST_TAILN;
      ST_TAILN:
        nxt_state = ST_IDLE;
      ST_REGC:
        nxt_state = dir_l ? ST_REGI : ST_IDLE;
      ST_REGI:
        nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  assign set_skip  = start &
                     ~cond_pass(instr_ff[`CTU_F_COND], flags_ff);
  assign set_undef = (state_ff == ST_OFFER) & refuse;
  assign set_abort = (state_ff == ST_MEMW) & mem_abort;
  assign set_done  = set_skip | set_undef | set_abort |
                     (busy & (nxt_state == ST_IDLE));
  assign set_wb    = instr_ff[`CTU_B_W] & (set_abort |
                     (state_ff == ST_TAILN));

  // ========================================================
  // Transfer engine
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff   <= ST_IDLE;
      addr_ff    <= `CTU_RST_WORD;
      first_ff   <= 1'b0;
      newbase_ff <= `CTU_RST_WORD;
      result_ff  <= `CTU_RST_WORD;
      regout_ff  <= `CTU_RST_WORD;
      cs_ff      <= {CNT_W{1'b0}};
      cn_ff      <= {CNT_W{1'b0}};
      ci_ff      <= {CNT_W{1'b0}};
      cc_ff      <= {CNT_W{1'b0}};
      trap_undef <= 1'b0;
      trap_abort <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      trap_undef <= set_undef;
      trap_abort <= set_abort;
      if (state_ff == ST_IDLE && nxt_state == ST_OFFER)
      begin
        cs_ff    <= {CNT_W{1'b0}};
        cn_ff    <= {CNT_W{1'b0}};
        ci_ff    <= {CNT_W{1'b0}};
        cc_ff    <= {CNT_W{1'b0}};
        first_ff <= 1'b1;
        // Register moves start with one S cycle
        if (is_reg)
          cs_ff  <= {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (state_ff == ST_OFFER && wait_busy)
        ci_ff    <= ci_ff + 1'b1;
      if (state_ff == ST_OFFER && accept)
      begin
        addr_ff  <= first_addr;
        regout_ff <= rd_is_pc ? pc_ff + `CTU_PC_SRC
                              : core_ff;
      end
      if (state_ff == ST_MEMW)
      begin
        first_ff <= 1'b0;
        addr_ff  <= addr_ff + `CTU_WORD_STEP;
        if (first_ff)
          cn_ff  <= cn_ff + 1'b1;
        else
          cs_ff  <= cs_ff + 1'b1;
      end
      if (state_ff == ST_TAILN)
        cn_ff    <= cn_ff + 1'b1;
      if (state_ff == ST_REGC)
      begin
        cc_ff    <= cc_ff + 1'b1;
        if (dir_l && !rd_is_pc)
          result_ff <= cp_reg_in;
      end
      if (state_ff == ST_REGI)
        ci_ff    <= ci_ff + 1'b1;
      if (set_wb)
        newbase_ff <= mod_base;
    end
  end

  // ========================================================
  // Software registers and sticky status
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_ff <= `CTU_RST_WORD;
      base_ff  <= `CTU_RST_WORD;
      pc_ff    <= `CTU_RST_WORD;
      core_ff  <= `CTU_RST_WORD;
      flags_ff <= 4'h0;
      done_ff  <= 1'b0;
      skip_ff  <= 1'b0;
      undef_ff <= 1'b0;
      abort_ff <= 1'b0;
      wb_ff    <= 1'b0;
    end
    else
    begin
      // Operands other than flags_ff are frozen while a transfer runs
      if (wr_acc && !busy)
      begin
        if (paddr == `CTU_OFS_INSTR)
          instr_ff <= pwdata;
        else if (paddr == `CTU_OFS_BASE)
          base_ff  <= pwdata;
        else if (paddr == `CTU_OFS_PC)
          pc_ff    <= pwdata;
        else if (paddr == `CTU_OFS_CORE)
          core_ff  <= pwdata;
        else if (paddr == `CTU_OFS_FLAGS)
          flags_ff <= pwdata[`CTU_F_NZCV];
      end
      if (state_ff == ST_REGC && dir_l && rd_is_pc)
        flags_ff <= cp_reg_in[`CTU_F_NZCV];
      // Set wins over write-one-to-clear
      done_ff  <= set_done  | (done_ff  & ~w1c[`CTU_B_DONE]);
      skip_ff  <= set_skip  | (skip_ff  & ~w1c[`CTU_B_SKIP]);
      undef_ff <= set_undef | (undef_ff & ~w1c[`CTU_B_UNDEF]);
      abort_ff <= set_abort | (abort_ff & ~w1c[`CTU_B_ABORT]);
      wb_ff    <= set_wb    | (wb_ff    & ~w1c[`CTU_B_WB]);
    end
  end

  // ========================================================
  // APB read path, zero wait states
  assign cost_word = {cc_ff, ci_ff, cn_ff, cs_ff};

  always @*
  begin
    nxt_prdata = `CTU_RST_WORD;
    nxt_err    = 1'b0;
    if (paddr == `CTU_OFS_CTRL)
      nxt_prdata = `CTU_RST_WORD;
    else if (paddr == `CTU_OFS_INSTR)
      nxt_prdata = instr_ff;
    else if (paddr == `CTU_OFS_BASE)
      nxt_prdata = base_ff;
    else if (paddr == `CTU_OFS_PC)
      nxt_prdata = pc_ff;
    else if (paddr == `CTU_OFS_CORE)
      nxt_prdata = core_ff;
    else if (paddr == `CTU_OFS_FLAGS)
      nxt_prdata[`CTU_F_NZCV] = flags_ff;
    else if (paddr == `CTU_OFS_STATUS)
    begin
      nxt_prdata[`CTU_B_BUSY]  = busy;
      nxt_prdata[`CTU_B_DONE]  = done_ff;
      nxt_prdata[`CTU_B_SKIP]  = skip_ff;
      nxt_prdata[`CTU_B_UNDEF] = undef_ff;
      nxt_prdata[`CTU_B_ABORT] = abort_ff;
      nxt_prdata[`CTU_B_WB]    = wb_ff;
    end
    else if (paddr == `CTU_OFS_NEWBASE)
      nxt_prdata = newbase_ff;
    else if (paddr == `CTU_OFS_RESULT)
      nxt_prdata = result_ff;
    else if (paddr == `CTU_OFS_COST)
      nxt_prdata = cost_word;
    else
      nxt_err    = 1'b1;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= `CTU_RST_WORD;
      err_ff <= 1'b0;
    end
    else if (psel && !penable)
    begin
      if (rd_setup)
        prdata <= nxt_prdata;
      err_ff <= nxt_err;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & err_ff;

  // ========================================================
  // Outputs to coprocessor and memory
  assign cp_instr      = instr_ff;
  assign cp_offer      = state_ff == ST_OFFER;
  assign mem_req       = state_ff == ST_MEMW;
  assign mem_write     = mem_req & ~dir_l;
  assign mem_seq       = mem_req & ~first_ff;
  assign mem_addr      = addr_ff;
  assign mem_wdata     = cp_store_data;
  assign cp_load_data  = mem_rdata;
  assign cp_load_valid = mem_req & dir_l & ~mem_abort;
  assign cp_reg_out    = regout_ff;
  assign cp_reg_valid  = (state_ff == ST_REGC) & ~dir_l;
endmodule // ctu_top

// ### hw/ctu_consts.vh
`ifndef CTU_CONSTS_VH
`define CTU_CONSTS_VH
// ==========================================================
// Register offsets (byte addresses)
`define CTU_OFS_CTRL    8'h00
`define CTU_OFS_INSTR   8'h04
`define CTU_OFS_BASE    8'h08
`define CTU_OFS_PC      8'h0c
`define CTU_OFS_CORE    8'h10
`define CTU_OFS_FLAGS   8'h14
`define CTU_OFS_STATUS  8'h18
`define CTU_OFS_NEWBASE 8'h1c
`define CTU_OFS_RESULT  8'h20
`define CTU_OFS_COST    8'h24
// ==========================================================
// Instruction fields
`define CTU_F_COND  31:28
`define CTU_B_REGX  25
`define CTU_B_P     24
`define CTU_B_U     23
`define CTU_B_W     21
`define CTU_B_L     20
`define CTU_F_RN    19:16
`define CTU_F_RD    15:12
`define CTU_F_OFS   7:0
// ==========================================================
// Status and control bits
`define CTU_B_START   0
`define CTU_B_BUSY    0
`define CTU_B_DONE    1
`define CTU_B_SKIP    2
`define CTU_B_UNDEF   3
`define CTU_B_ABORT   4
`define CTU_B_WB      5
`define CTU_ST_W1C    5:1
`define CTU_F_NZCV    31:28
`define CTU_B_FN      3
`define CTU_B_FZ      2
`define CTU_B_FC      1
`define CTU_B_FV      0
// ==========================================================
// Cost fields: S, N, I, C cycle counts
`define CTU_F_CS    7:0
`define CTU_F_CN    15:8
`define CTU_F_CI    23:16
`define CTU_F_CC    31:24
// ==========================================================
// Constants
`define CTU_PC_IDX     4'hf
`define CTU_PC_BASE    32'h00000008
`define CTU_PC_SRC     32'h0000000c
`define CTU_WORD_STEP  32'h00000004
`define CTU_OFS_SHIFT  2
`define CTU_RST_WORD   32'h00000000
// ==========================================================
// Condition codes
`define CTU_C_EQ 4'h0
`define CTU_C_NE 4'h1
`define CTU_C_CS 4'h2
`define CTU_C_CC 4'h3
`define CTU_C_MI 4'h4
`define CTU_C_PL 4'h5
`define CTU_C_VS 4'h6
`define CTU_C_VC 4'h7
`define CTU_C_HI 4'h8
`define CTU_C_LS 4'h9
`define CTU_C_GE 4'ha
`define CTU_C_LT 4'hb
`define CTU_C_GT 4'hc
`define CTU_C_LE 4'hd
`define CTU_C_AL 4'he
`endif

// ### hw/ctu_addr_gen.v
`include "ctu_consts.vh"
// ==========================================================
// Transfer address and modified base
module ctu_addr_gen
(
  // Operands
  input  wire [31:0] base,
  input  wire [31:0] pc,
  input  wire        base_is_pc,
  input  wire [7:0]  ofs_words,
  input  wire        up,
  input  wire        pre,
  // Results
  output wire [31:0] first_addr,
  output wire [31:0] new_base
);
  wire [31:0] eff_base;
  wire [31:0] ofs_bytes;

  assign eff_base   = base_is_pc ? pc + `CTU_PC_BASE : base;
  assign ofs_bytes  = {22'h000000, ofs_words, 2'h0};
  assign new_base   = up ? eff_base + ofs_bytes
                         : eff_base - ofs_bytes;
  // Low two bits kept, no forced alignment
  assign first_addr = pre ? new_base : eff_base;
endmodule // ctu_addr_gen

// ### testbench/ctu_checker.sv
// ==========================================================
// Port checker for the transfer unit
module ctu_checker
(
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // Coprocessor side
  input wire [31:0] cp_instr,
  input wire        cp_offer,
  input wire        coproc_absent_line,
  input wire        coproc_busy_line,
  input wire [31:0] cp_store_data,
  input wire [31:0] cp_load_data,
  input wire        cp_load_valid,
  // Memory side
  input wire        mem_req,
  input wire        mem_write,
  input wire        mem_seq,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire        mem_abort,
  // Traps
  input wire        trap_undef,
  input wire        trap_abort
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_refused;
    cp_offer && coproc_absent_line && coproc_busy_line;
  endsequence
  sequence s_waiting;
    cp_offer && !coproc_absent_line && coproc_busy_line;
  endsequence
  sequence s_accept;
    cp_offer && !coproc_absent_line && !coproc_busy_line;
  endsequence
  sequence s_aborted;
    mem_req && mem_abort;
  endsequence

  a_addr_step_four: assert property (mem_req && $past(mem_req) |->
    mem_addr == $past(mem_addr) + 32'h00000004)
    else $error("word address did not step by four");
  a_first_nonseq: assert property ($rose(mem_req) |-> !mem_seq)
    else $error("first word flagged sequential");
  a_later_seq: assert property (mem_req && $past(mem_req) |-> mem_seq)
    else $error("later word not flagged sequential");
  a_store_data_pass: assert property (mem_req && mem_write |->
    mem_wdata == cp_store_data)
    else $error("store data not taken from coprocessor");
  a_load_data_pass: assert property (cp_load_valid |->
    cp_load_data == mem_rdata && mem_req && !mem_write && !mem_abort)
    else $error("load word not passed to coprocessor");
  a_refuse_undef: assert property (s_refused |=>
    trap_undef && !cp_offer ##1 !trap_undef)
    else $error("refused offer did not trap once");
  a_busy_wait_holds: assert property (s_waiting |=> cp_offer && !mem_req)
    else $error("busy coprocessor not waited for");
  a_accept_starts: assert property (s_accept |=> !cp_offer &&
    (mem_req == !$past(cp_instr[25])))
    else $error("accepted transfer did not start");
  a_offer_no_mem: assert property (cp_offer |-> !mem_req)
    else $error("memory cycle during offer");
  a_abort_trap: assert property (s_aborted |=> trap_abort && !mem_req)
    else $error("aborted word did not trap");
endmodule // ctu_checker

bind ctu_top ctu_checker i_chk (.pclk, .presetn, .cp_instr, .cp_offer,
  .coproc_absent_line, .coproc_busy_line, .cp_store_data, .cp_load_data,
  .cp_load_valid, .mem_req, .mem_write, .mem_seq, .mem_addr, .mem_wdata,
  .mem_rdata, .mem_abort, .trap_undef, .trap_abort);

// ### testbench/ctu_coproc_model.sv
// ==========================================================
// Coprocessor and memory on the far side
module ctu_coproc_model
#(
  parameter logic [3:0] CP_NUM   = 4'h1,
  parameter logic [3:0] LONG_LEN = 4'h2
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // From the unit
  input  wire logic        cp_offer,
  input  wire logic [31:0] cp_instr,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  // Scenario controls
  input  wire logic [3:0]  busy_n,
  input  wire logic        abort_en,
  input  wire logic [31:0] reg_word,
  // To the unit
  output logic             coproc_absent_line,
  output logic             coproc_busy_line,
  output logic             cp_last,
  output logic [31:0]      cp_store_data,
  output logic [31:0]      cp_reg_in,
  output logic [31:0]      mem_rdata,
  output logic             mem_abort
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_ff;
  logic [3:0] word_ff;
  logic       match;
  logic [3:0] len;

  assign match = cp_instr[11:8] == CP_NUM;
  assign len = cp_instr[22] ? LONG_LEN : 4'h1;
  // Word count restarts on every offer, so a reissue replays cleanly
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wait_ff <= 4'h0;
      word_ff <= 4'h0;
    end
    else if (cp_offer)
    begin
      word_ff <= 4'h0;
      if (match && wait_ff < busy_n)
        wait_ff <= wait_ff + 4'h1;
    end
    else
    begin
      wait_ff <= 4'h0;
      if (mem_req)
        word_ff <= word_ff + 4'h1;
    end
  assign coproc_absent_line = !cp_offer || !match;
  assign coproc_busy_line = !cp_offer || !match || wait_ff < busy_n;
  assign cp_last = mem_req && word_ff == len - 4'h1;
  assign cp_store_data = {28'hc0de000, word_ff};
  assign cp_reg_in = reg_word;
  // Idle memory bus shows the inverted address, never the last word
  assign mem_rdata = mem_req ? mem_addr ^ 32'h5a5a0000 : ~mem_addr;
  assign mem_abort = mem_req && abort_en;
endmodule // ctu_coproc_model

// ### testbench/ctu_top_bench.sv
`include "ctu_consts.vh"
module ctu_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] B = 32'h10000102;
  localparam logic [31:0] P = 32'h00000200;
  localparam logic [31:0] M = 32'hffffffff;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, cp_instr, cp_store_data, cp_load_data;
  logic [31:0] cp_reg_in, cp_reg_out, mem_addr, mem_wdata, mem_rdata;
  logic        cp_offer, absent, busy, cp_last, cp_load_valid;
  logic        cp_reg_valid, mem_req, mem_write, mem_seq, mem_abort;
  logic        trap_undef, trap_abort, abort_en, slv_q;
  logic [3:0]  busy_n;
  logic [31:0] reg_word, rd_q, n_words, n_aborts, n_undefs;
  logic [31:0] reg_cap, instr_cap, cycles;
  logic [31:0] addr_log [0:3];
  int          num_errors = 0;
  int          n_compared = 0;

  ctu_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cp_instr, .cp_offer,
    .coproc_absent_line(absent), .coproc_busy_line(busy), .cp_last,
    .cp_store_data, .cp_load_data, .cp_load_valid, .cp_reg_in,
    .cp_reg_out, .cp_reg_valid, .mem_req, .mem_write, .mem_seq,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_abort, .trap_undef,
    .trap_abort);
  ctu_coproc_model i_cp (.pclk, .presetn, .cp_offer, .cp_instr, .mem_req,
    .mem_addr, .busy_n, .abort_en, .reg_word,
    .coproc_absent_line(absent), .coproc_busy_line(busy), .cp_last,
    .cp_store_data, .cp_reg_in, .mem_rdata, .mem_abort);

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ==========================================================
  // Monitor and timeout
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (mem_req && n_words < 4)
      addr_log[n_words] <= mem_addr;
    if (mem_req)
      n_words <= n_words + 1;
    if (trap_abort)
      n_aborts <= n_aborts + 1;
    if (trap_undef)
      n_undefs <= n_undefs + 1;
    if (cp_reg_valid)
      reg_cap <= cp_reg_out;
    if (cp_offer)
      instr_cap <= cp_instr;
    if (cycles == 32'd5000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  // ==========================================================
  // Tasks
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_q = prdata;
    slv_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd_q & m, e);
  endtask
  task run(input logic [31:0] ins);
    int k;
    n_words = 0;
    apb(1'b1, `CTU_OFS_STATUS, 32'h0000003e);
    apb(1'b1, `CTU_OFS_INSTR, ins);
    apb(1'b1, `CTU_OFS_CTRL, 32'h00000001);
    k = 0;
    do
    begin
      apb(1'b0, `CTU_OFS_STATUS, 32'h0);
      k++;
    end while (rd_q[0] !== 1'b0 && k < 40);
    cmp({31'h0, rd_q[0]}, 32'h0);
    $display("test %h done", ins);
  endtask
  task print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, abort_en, slv_q} = 6'h0;
    {paddr, pwdata, rd_q, reg_cap, instr_cap, cycles} = '0;
    {n_words, n_aborts, n_undefs, busy_n} = '0;
    reg_word = 32'ha5a55a5a;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `CTU_OFS_BASE, B);
    apb(1'b1, `CTU_OFS_PC, P);
    apb(1'b1, `CTU_OFS_CORE, 32'h12345678);
    apb(1'b1, `CTU_OFS_FLAGS, 32'h0);
    run(32'hedf42103);
    cmp(addr_log[0], B + 32'hc);
    cmp(addr_log[1], B + 32'h10);
    rdc(`CTU_OFS_NEWBASE, M, B + 32'hc);
    rdc(`CTU_OFS_STATUS, 32'h22, 32'h22);
    rdc(`CTU_OFS_COST, M, 32'h00000201);
    busy_n <= 4'h2;
    run(32'hec243105);
    cmp(addr_log[0], B);
    cmp(n_words, 32'h1);
    rdc(`CTU_OFS_STATUS, 32'h20, 32'h20);
    rdc(`CTU_OFS_NEWBASE, M, B - 32'h14);
    rdc(`CTU_OFS_COST, M, 32'h00020200);
    busy_n <= 4'h0;
    run(32'hed9f0101);
    cmp(addr_log[0], P + 32'hc);
    rdc(`CTU_OFS_STATUS, 32'h20, 32'h0);
    abort_en <= 1'b1;
    run(32'heda40102);
    abort_en <= 1'b0;
    rdc(`CTU_OFS_STATUS, 32'h30, 32'h30);
    rdc(`CTU_OFS_NEWBASE, M, B + 32'h8);
    cmp(n_aborts, 32'h1);
    run(32'hed940701);
    rdc(`CTU_OFS_STATUS, 32'h08, 32'h08);
    cmp(n_undefs, 32'h1);
    run(32'h0d940101);
    rdc(`CTU_OFS_STATUS, 32'h04, 32'h04);
    cmp(n_words, 32'h0);
    run(32'hee75f156);
    rdc(`CTU_OFS_FLAGS, M, 32'ha0000000);
    rdc(`CTU_OFS_COST, M, 32'h01010001);
    busy_n <= 4'h1;
    run(32'hee753156);
    rdc(`CTU_OFS_RESULT, M, 32'ha5a55a5a);
    rdc(`CTU_OFS_COST, M, 32'h01020001);
    busy_n <= 4'h0;
    run(32'hee65f156);
    cmp(reg_cap, P + 32'hc);
    rdc(`CTU_OFS_COST, M, 32'h01000001);
    cmp(instr_cap, 32'hee65f156);
    run(32'hee653156);
    cmp(reg_cap, 32'h12345678);
    apb(1'b0, 8'h40, 32'h0);
    cmp({31'h0, slv_q}, 32'h1);
    cmp(rd_q, 32'h0);
    print_verdict;
  end
endmodule // ctu_top_bench
